// ### testbench/fps_chk.sv
/* Checker of the frequency protection stages block: APB answer and event
   relations. Sees only the design top ports; bound after the module. */
`timescale 1ns/100ps
`default_nettype none
module fps_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  start,
  input wire logic [7:0]  trip,
  input wire logic [7:0]  blocked,
  input wire logic [23:0] evt_on,
  input wire logic [23:0] evt_off,
  input wire logic [31:0] evt_stamp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Relations
  // ----------------------------------------
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("refused data");
  property p_son; evt_on[7:0] == (start & ~$past(start)); endproperty
  a_son: assert property (p_son) else $error("start on");
  property p_toff; evt_off[15:8] == ($past(trip) & ~trip); endproperty
  a_toff: assert property (p_toff) else $error("trip off");
  property p_bon; evt_on[23:16] == (blocked & ~$past(blocked)); endproperty
  a_bon: assert property (p_bon) else $error("block on");
  property p_ton; evt_on[15:8] == (trip & ~$past(trip)); endproperty
  a_ton: assert property (p_ton) else $error("trip on");
  property p_soff; evt_off[7:0] == ($past(start) & ~start); endproperty
  a_soff: assert property (p_soff) else $error("start off");
  property p_boff; evt_off[23:16] == ($past(blocked) & ~blocked); endproperty
  a_boff: assert property (p_boff) else $error("block off");
  property p_trs; (trip & ~start) == 8'h0; endproperty
  a_trs: assert property (p_trs) else $error("trip alone");
  property p_sbk; (start & blocked) == 8'h0; endproperty
  a_sbk: assert property (p_sbk) else $error("start blocked");
  property p_stm; evt_on != 24'h0 |-> evt_stamp >= $past(evt_stamp); endproperty
  a_stm: assert property (p_stm) else $error("stamp back");
endmodule
bind fps_frequency_function_block fps_chk i_chk (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .prdata, .start, .trip, .blocked, .evt_on, .evt_off, .evt_stamp);
`default_nettype wire

// ### testbench/tb_frequency_protection_stages.sv
/* Directed testbench of the frequency protection stages block.
   Assumes the register header; MS_CYCLES is cut to 10 cycles. */
`timescale 1ns/100ps
`default_nettype none
`include "fps_regs.vh"
module tb_frequency_protection_stages;
  reg         pclk = 0;
  reg         presetn = 0;
  reg         psel = 0;
  reg         penable = 0;
  reg         pwrite = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0;
  reg  [15:0] f1 = 16'h1388;
  reg  [15:0] f2 = 16'h1388;
  reg         v1 = 0;
  reg         v2 = 0;
  reg         block_in = 0;
  wire [31:0] prdata;
  wire [31:0] evt_stamp;
  wire [23:0] evt_on;
  wire [23:0] evt_off;
  wire [7:0]  start;
  wire [7:0]  trip;
  wire [7:0]  blocked;
  wire        pready;
  wire        pslverr;
  wire        irq;
  reg  [31:0] rd;
  reg  [31:0] s_s;
  reg  [31:0] s_t;
  reg         er;
  integer     n_errors = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     t_s;
  integer     t_t;
  integer     m;
  fps_frequency_function_block #(.MS_CYCLES(10)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_first_voltage_transformer(f1), .freq_first_valid(v1),
    .freq_second_voltage_transformer(f2), .freq_second_valid(v2), .block_in(block_in),
    .start(start), .trip(trip), .blocked(blocked), .evt_on(evt_on), .evt_off(evt_off),
    .evt_stamp(evt_stamp), .irq(irq));
  initial forever #2.5 pclk = ~pclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Event times of stages 0 and 4 for the instant and delay checks
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (evt_on[0] | evt_on[4]) begin
      t_s = cyc;
      s_s = evt_stamp;
    end
    if (evt_on[8] | evt_on[12]) begin
      t_t = cyc;
      s_t = evt_stamp;
    end
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // One valid pulse on the chosen source, then time for outputs to settle
  task freq(input s, input [15:0] v);
    begin
      @(posedge pclk);
      f1 <= s ? f1 : v;
      f2 <= s ? v : f2;
      v1 <= !s;
      v2 <= s;
      @(posedge pclk);
      v1 <= 0;
      v2 <= 0;
      repeat (4) @(posedge pclk);
      #1;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reg;
    begin
      apb(0, `FPS_CTRL, 0);
      chk("ctrl", rd, 32'h1);
      apb(0, `FPS_ENABLE, 0);
      chk("enable", rd, 32'h5555);
      apb(0, 12'h100, 0);
      chk("unmap", {rd[30:0], er}, 32'h1);
      apb(1, 12'h200, 32'h13ec);
      apb(1, 12'h204, 32'h0);
      apb(1, 12'h220, 32'h1324);
      apb(1, 12'h224, 32'h2);
      apb(1, 12'h240, 32'h1450);
      apb(1, 12'h244, 32'h0);
      apb(1, 12'h260, 32'h1324);
      apb(1, 12'h264, 32'h2);
      // Park the frequency between the pick-ups before the stages come on
      freq(0, 16'h1388);
      apb(1, `FPS_ENABLE, 32'h5656);
      $display("test reg done");
    end
  endtask
  task t_over;
    begin
      freq(0, 16'h13ec);
      chk("equal", start, 8'h0);
      freq(0, 16'h13ed);
      chk("start", start, 8'h1);
      chk("trip", trip, 8'h1);
      chk("inst", t_t - t_s, 0);
      chk("stamp", s_t, s_s);
      freq(0, 16'h13eb);
      chk("hold", start, 8'h1);
      freq(0, 16'h13ea);
      chk("rel", start | trip, 8'h0);
      $display("test over done");
    end
  endtask
  task t_under;
    begin
      freq(0, 16'h1323);
      chk("under", start, 8'h10);
      chk("early", trip, 8'h0);
      repeat (25) @(posedge pclk);
      chk("late", trip, 8'h10);
      chk("delay", (t_t - t_s) >= 9 && (t_t - t_s) <= 21, 1);
      apb(0, `FPS_CNT_START, 0);
      chk("cnt_st", rd, 32'h2);
      apb(0, `FPS_CNT_TRIP, 0);
      chk("cnt_tr", rd, 32'h2);
      freq(0, 16'h1326);
      apb(1, `FPS_CNT_CLR, 32'h1);
      apb(0, `FPS_CNT_START, 0);
      chk("clr", rd, 32'h0);
      $display("test under done");
    end
  endtask
  task t_block;
    begin
      apb(1, `FPS_IRQ_MASK, 32'h0);
      apb(0, `FPS_IRQ_STAT, 0);
      chk("stat", rd, 32'h3);
      chk("masked", irq, 1'b0);
      apb(1, `FPS_IRQ_MASK, 32'h4);
      block_in <= 1;
      freq(0, 16'h13ed);
      chk("blk", blocked, 8'h1);
      chk("nostart", start, 8'h0);
      chk("irq", irq, 1'b1);
      apb(1, `FPS_IRQ_STAT, 32'h4);
      apb(0, `FPS_CNT_BLOCK, 0);
      chk("cnt_bk", rd, 32'h1);
      chk("irqclr", irq, 1'b0);
      block_in <= 0;
      freq(0, 16'h13ea);
      $display("test block done");
    end
  endtask
  task t_mode;
    begin
      for (m = 1; m <= 5; m = m + 1) begin
        apb(1, `FPS_CTRL, m);
        freq(0, 16'h13ed);
        chk("m_st", start[0], m == 1 || m == 3);
        chk("m_bk", blocked[0], m == 2 || m == 4);
        freq(0, 16'h13ea);
      end
      $display("test mode done");
    end
  endtask
  task t_group;
    begin
      apb(1, `FPS_CTRL, 32'h11);
      apb(0, `FPS_ENABLE, 0);
      chk("static", rd, 32'h5656);
      freq(0, 16'h13ed);
      chk("g1_lo", start, 8'h0);
      freq(0, 16'h1451);
      chk("g1_hi", start, 8'h1);
      apb(1, `FPS_CTRL, 32'h1001);
      freq(1, 16'h1388);
      chk("track2", start, 8'h0);
      freq(0, 16'h1451);
      chk("track1", start, 8'h0);
      $display("test group done");
    end
  endtask
  task t_force;
    begin
      apb(1, `FPS_FORCE, 32'he);
      apb(1, `FPS_CTRL, 32'h101);
      repeat (3) @(posedge pclk);
      #1;
      chk("forced", {blocked, trip, start}, 24'h020101);
      $display("test force done");
    end
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reg;
    t_over;
    t_under;
    t_block;
    t_mode;
    t_group;
    t_force;
    wrap_up;
  end
endmodule
`default_nettype wire

// ### verilog/fps_frequency_function_block.v
/*
  Frequency protection stages: four over- and four underfrequency stages,
  eight setting groups, start/trip/blocked outputs, ON/OFF events with
  millisecond stamps, cumulative counters, APB registers and interrupt.
  Assumes pclk at 200 MHz and frequency samples synchronous to pclk.
*/
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fps_regs.vh"

module fps_frequency_function_block #(
  parameter MS_CYCLES = `FPS_MS_US * `FPS_CLK_MHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] freq_first_voltage_transformer,
  input  wire        freq_first_valid,
  input  wire [15:0] freq_second_voltage_transformer,
  input  wire        freq_second_valid,
  input  wire        block_in,
  output reg  [7:0]  start,
  output reg  [7:0]  trip,
  output reg  [7:0]  blocked,
  output reg  [23:0] evt_on,
  output reg  [23:0] evt_off,
  output reg  [31:0] evt_stamp,
  output reg         irq
);
  localparam [15:0] HYST = `FPS_HYST_MHZ / `FPS_FREQ_LSB_MHZ;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Counts the stages that raise one event kind in a cycle
  function [3:0] pop8;
    input [7:0] v;
    integer k;
    begin
      pop8 = 4'h0;
      for (k = 0; k < 8; k = k + 1)
        pop8 = pop8 + {3'h0, v[k]};
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [2:0]  mode;
  reg  [2:0]  group;
  reg         force_en;
  reg         track;
  reg  [15:0] enable;
  reg  [15:0] force_st;
  reg  [2:0]  irq_stat;
  reg  [2:0]  irq_mask;
  reg  [31:0] cnt_start;
  reg  [31:0] cnt_trip;
  reg  [31:0] cnt_block;
  reg  [31:0] stamp;
  reg  [17:0] ms_div;
  reg  [15:0] freq;
  // Setting memory has no reset: software writes every entry in use first
  reg  [15:0] pick_mem [0:63];
  reg  [20:0] dly_mem [0:63];
  reg  [7:0]  pick;
  reg  [7:0]  st;
  reg  [7:0]  tr;
  reg  [7:0]  bl;
  reg  [20:0] tmr [0:7];

  wire setup   = psel & ~penable;
  wire wr_en   = psel & penable & pready & pwrite;
  wire set_hit = paddr[11:9] == `FPS_SET_BASE;
  wire [5:0] set_idx = paddr[8:3];
  wire ms_tick = ms_div == MS_CYCLES - 1;
  wire clr_cnt = wr_en & (paddr == `FPS_CNT_CLR) & pwdata[0];

  // ----------------------------------------
  // Stage evaluation
  // ----------------------------------------
  reg  [7:0]  next_pick;
  reg  [7:0]  next_st;
  reg  [7:0]  next_tr;
  reg  [7:0]  next_bl;
  reg  [20:0] next_tmr [0:7];
  reg  [7:0]  next_start;
  reg  [7:0]  next_trip;
  reg  [7:0]  next_blocked;
  reg  [15:0] pu;
  reg  [20:0] dly;
  reg         on;
  reg         blk;
  reg         above;
  integer     i;
  // Own loop index for the clocked process, so each index has one driver
  integer     j;

  always @* begin
    pu = 16'h0;
    dly = 21'h0;
    // Modes outside 1..4 (5 and unused codes) behave as off
    on  = (mode >= `FPS_MODE_ON) && (mode <= `FPS_MODE_TBLK);
    blk = block_in | (mode == `FPS_MODE_BLK) | (mode == `FPS_MODE_TBLK);
    for (i = 0; i < 8; i = i + 1) begin
      pu  = pick_mem[{group, i[2:0]}];
      dly = dly_mem[{group, i[2:0]}];
      // Released stages need the plain crossing, picked ones the hysteresis
      if (i < 4) begin
        above = pick[i] ? (freq + HYST > pu) : (freq > pu);
        next_pick[i] = above;
      end else begin
        above = pick[i] ? (freq < pu + HYST) : (freq < pu);
        next_pick[i] = above;
      end
      if (!on || enable[2*i +: 2] != `FPS_EN_YES)
        next_pick[i] = 1'b0;
      next_bl[i] = next_pick[i] & (bl[i] | (~pick[i] & blk));
      next_st[i] = next_pick[i] & ~next_bl[i] & ~blk;
      if (!next_st[i])
        next_tmr[i] = 21'h0;
      else if (ms_tick && tmr[i] < dly)
        next_tmr[i] = tmr[i] + 21'h1;
      else
        next_tmr[i] = tmr[i];
      next_tr[i] = next_st[i] & (next_tmr[i] >= dly);
      next_start[i]   = next_st[i];
      next_trip[i]    = next_tr[i];
      next_blocked[i] = next_bl[i];
      if (force_en && force_st[2*i +: 2] != 2'h0) begin
        next_start[i]   = force_st[2*i +: 2] != `FPS_FRC_BLOCK;
        next_trip[i]    = force_st[2*i +: 2] == `FPS_FRC_TRIP;
        next_blocked[i] = force_st[2*i +: 2] == `FPS_FRC_BLOCK;
      end
    end
  end

  wire [7:0] on_st = next_start & ~start;
  wire [7:0] on_tr = next_trip & ~trip;
  wire [7:0] on_bl = next_blocked & ~blocked;

  // ----------------------------------------
  // Stage state, outputs and events
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pick      <= 8'h0;
      st        <= 8'h0;
      tr        <= 8'h0;
      bl        <= 8'h0;
      for (j = 0; j < 8; j = j + 1)
        tmr[j] <= 21'h0;
      start     <= 8'h0;
      trip      <= 8'h0;
      blocked   <= 8'h0;
      evt_on    <= 24'h0;
      evt_off   <= 24'h0;
      evt_stamp <= 32'h0;
      ms_div    <= 18'h0;
      stamp     <= 32'h0;
      freq      <= 16'h0;
    end else begin
      pick    <= next_pick;
      st      <= next_st;
      tr      <= next_tr;
      bl      <= next_bl;
      for (j = 0; j < 8; j = j + 1)
        tmr[j] <= next_tmr[j];
      start   <= next_start;
      trip    <= next_trip;
      blocked <= next_blocked;
      // One shared stamp for all edges of a cycle keeps instant pairs equal
      evt_on    <= {on_bl, on_tr, on_st};
      evt_off   <= {~next_blocked & blocked, ~next_trip & trip, ~next_start & start};
      evt_stamp <= stamp;
      ms_div  <= ms_tick ? 18'h0 : ms_div + 18'h1;
      if (ms_tick)
        stamp <= stamp + 32'h1;
      // The held sample stays in use until the selected source gives a new one
      if (!track && freq_first_valid)
        freq <= freq_first_voltage_transformer;
      else if (track && freq_second_valid)
        freq <= freq_second_voltage_transformer;
    end
  end

  // ----------------------------------------
  // APB slave, counters and interrupt
  // ----------------------------------------
  wire [2:0] irq_ev = {|on_bl, |on_tr, |on_st};

  always @(posedge pclk) begin
    if (wr_en && set_hit && !paddr[2])
      pick_mem[set_idx] <= pwdata[15:0];
    if (wr_en && set_hit && paddr[2])
      dly_mem[set_idx] <= pwdata[20:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode      <= `FPS_MODE_ON;
      group     <= 3'h0;
      force_en  <= 1'b0;
      track     <= 1'b0;
      enable    <= `FPS_EN_RST;
      force_st  <= 16'h0;
      irq_stat  <= 3'h0;
      irq_mask  <= 3'h0;
      cnt_start <= 32'h0;
      cnt_trip  <= 32'h0;
      cnt_block <= 32'h0;
      irq       <= 1'b0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (wr_en) begin
        // Static settings: no setting group write touches these
        if (paddr == `FPS_CTRL) begin
          mode     <= pwdata[`FPS_MODE_LSB +: 3];
          group    <= pwdata[`FPS_GRP_LSB +: 3];
          force_en <= pwdata[`FPS_FORCE_BIT];
          track    <= pwdata[`FPS_TRACK_BIT];
        end else if (paddr == `FPS_ENABLE)
          enable <= pwdata[15:0];
        else if (paddr == `FPS_FORCE)
          force_st <= pwdata[15:0];
        else if (paddr == `FPS_IRQ_MASK)
          irq_mask <= pwdata[2:0];
      end
      // A new event wins over a clear in the same cycle
      if (wr_en && paddr == `FPS_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[2:0]) | irq_ev;
      else
        irq_stat <= irq_stat | irq_ev;
      irq <= |((irq_stat | irq_ev) & irq_mask);
      // Counters wrap at 32 bits; a clear and an event in one cycle keep the event
      cnt_start <= (clr_cnt ? 32'h0 : cnt_start) + {28'h0, pop8(on_st)};
      cnt_trip  <= (clr_cnt ? 32'h0 : cnt_trip) + {28'h0, pop8(on_tr)};
      cnt_block <= (clr_cnt ? 32'h0 : cnt_block) + {28'h0, pop8(on_bl)};
      if (setup) begin
        prdata <= 32'h0;
        if (paddr == `FPS_CTRL)
          prdata <= {19'h0, track, 3'h0, force_en, 1'b0, group, 1'b0, mode};
        else if (paddr == `FPS_ENABLE)
          prdata <= {16'h0, enable};
        else if (paddr == `FPS_FORCE)
          prdata <= {16'h0, force_st};
        else if (paddr == `FPS_STATUS)
          prdata <= {8'h0, blocked, trip, start};
        else if (paddr == `FPS_IRQ_STAT)
          prdata <= {29'h0, irq_stat};
        else if (paddr == `FPS_IRQ_MASK)
          prdata <= {29'h0, irq_mask};
        else if (paddr == `FPS_CNT_START)
          prdata <= cnt_start;
        else if (paddr == `FPS_CNT_TRIP)
          prdata <= cnt_trip;
        else if (paddr == `FPS_CNT_BLOCK)
          prdata <= cnt_block;
        else if (paddr == `FPS_CNT_CLR)
          prdata <= 32'h0;
        else if (paddr == `FPS_STAMP)
          prdata <= stamp;
        else if (paddr == `FPS_FREQ)
          prdata <= {16'h0, freq};
        else if (set_hit && !paddr[2])
          prdata <= {16'h0, pick_mem[set_idx]};
        else if (set_hit)
          prdata <= {11'h0, dly_mem[set_idx]};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/fps_regs.vh
/*
  Register map, field positions, reset values and timing constants of the
  frequency protection stages block. Assumes a 32-bit APB slave, byte addresses.
*/
`ifndef FPS_REGS_VH
`define FPS_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define FPS_CTRL      12'h000
`define FPS_ENABLE    12'h004
`define FPS_FORCE     12'h008
`define FPS_STATUS    12'h00c
`define FPS_IRQ_STAT  12'h010
`define FPS_IRQ_MASK  12'h014
`define FPS_CNT_START 12'h018
`define FPS_CNT_TRIP  12'h01c
`define FPS_CNT_BLOCK 12'h020
`define FPS_CNT_CLR   12'h024
`define FPS_STAMP     12'h028
`define FPS_FREQ      12'h02c
// Setting memory: 0x200 + (group*8 + stage)*8, +0 pick-up, +4 delay
`define FPS_SET_BASE  3'b001
// ----------------------------------------
// CTRL fields and reset values
// ----------------------------------------
`define FPS_MODE_LSB  0
`define FPS_GRP_LSB   4
`define FPS_FORCE_BIT 8
`define FPS_TRACK_BIT 12
`define FPS_MODE_ON   3'h1
`define FPS_MODE_BLK  3'h2
`define FPS_MODE_TEST 3'h3
`define FPS_MODE_TBLK 3'h4
`define FPS_MODE_OFF  3'h5
`define FPS_EN_YES    2'h2
`define FPS_EN_RST    16'h5555
`define FPS_FRC_START 2'h1
`define FPS_FRC_TRIP  2'h2
`define FPS_FRC_BLOCK 2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define FPS_CLK_MHZ   200
`define FPS_MS_US     1000
// Hysteresis 20 mHz in 10 mHz frequency units
`define FPS_HYST_MHZ  20
`define FPS_FREQ_LSB_MHZ 10
`endif
